// ===== hw/isa_swap_pkg.sv
package isa_swap_pkg;

  // Clock and refresh timing
  localparam int unsigned CLK_PERIOD_PS     = 4000;
  localparam int unsigned REFRESH_PERIOD_NS = 15000;
  localparam int unsigned REFRESH_CYCLES    = (REFRESH_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned REFRESH_CNT_W     = 12;

  // Address widths and decode
  localparam int unsigned LA_W           = 7;
  localparam int unsigned IO_ADDR_W      = 16;
  localparam int unsigned IO_PLAT_MSB    = 15;
  localparam int unsigned IO_PLAT_LSB    = 8;
  localparam int unsigned IRQ_W          = 16;
  localparam int unsigned BYTE_W         = 8;

  // Platform 16-bit memory map, in 128KB blocks (LA<23..17> values)
  localparam logic [6:0] DRAM_TOP_BLOCK  = 7'h04;
  localparam logic [6:0] ROM_BLOCK_LOW   = 7'h07;
  localparam logic [6:0] ROM_BLOCK_HIGH  = 7'h7f;

  typedef enum logic [5:0] {
    PATH_NONE = 6'h01,
    PATH_LL   = 6'h02,
    PATH_HH   = 6'h04,
    PATH_WORD = 6'h08,
    PATH_H2L  = 6'h10,
    PATH_L2H  = 6'h20
  } path_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h1,
    ST_ACTIVE = 2'h2
  } cyc_state_e;

  typedef struct packed {
    logic       active;
    logic       read;
    logic       io;
    logic       dma;
    logic       refresh;
    logic       sbhe_n;
    logic       a0;
    logic       mcs16_n;
    logic       iocs16_n;
  } cyc_req_s;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
  } data_s;

endpackage

// ===== hw/isa_byte_swap_and_sizing.sv
`timescale 1ns/1ns
`default_nettype none

module isa_byte_swap_and_sizing (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire isa_swap_pkg::cyc_req_s  req,
  input  wire isa_swap_pkg::data_s     data_in,
  input  wire logic [6:0]              la,
  input  wire logic [15:0]             io_addr,
  input  wire logic [15:0]             irq_line,
  output logic                         mcs16_plat_oe,
  output logic                         io_plat_sel,
  output logic                         io_bus_sel,
  output logic                         refresh_req,
  output logic [15:0]                  irq_event,
  output logic                         cycle_16,
  output logic                         dma_illegal,
  output isa_swap_pkg::path_e          path,
  output isa_swap_pkg::data_s          data_out,
  output logic                         lo_oe,
  output logic                         hi_oe
);

  isa_swap_pkg::cyc_state_e state;
  isa_swap_pkg::cyc_state_e next_state;
  isa_swap_pkg::path_e      next_path;
  isa_swap_pkg::data_s      next_data_out;
  logic                     next_lo_oe;
  logic                     next_hi_oe;
  logic                     next_cycle_16;
  logic                     next_dma_illegal;
  isa_swap_pkg::path_e      start_path;
  logic                     start_16;
  logic                     start_illegal;
  logic                     xcs16;
  logic                     mem16;

  // Path choice made once at command start; a cycle begun as 8-bit stays 8-bit
  always_comb begin
    xcs16         = req.io ? ~req.iocs16_n : ~req.mcs16_n;
    mem16         = ~req.mcs16_n;
    start_path    = isa_swap_pkg::PATH_NONE;
    start_16      = 1'b0;
    start_illegal = 1'b0;
    if (req.refresh) begin
      start_path = isa_swap_pkg::PATH_NONE;
    end else if (req.dma) begin
      if (!req.a0 && req.sbhe_n) begin
        start_path = isa_swap_pkg::PATH_LL;
      end else if (req.a0) begin
        if (mem16) begin
          start_path = req.read ? isa_swap_pkg::PATH_H2L : isa_swap_pkg::PATH_L2H;
        end else begin
          start_path = isa_swap_pkg::PATH_LL;
        end
      end else if (mem16) begin
        start_path = isa_swap_pkg::PATH_WORD;
        start_16   = 1'b1;
      end else begin
        start_illegal = 1'b1;
      end
      // Cycle size for DMA follows SBHE/A0 and mcs16_n only; iocs16_n is not sensed
    end else begin
      unique case ({req.sbhe_n, req.a0})
        2'b10: start_path = isa_swap_pkg::PATH_LL;
        2'b01: begin
          if (xcs16) begin
            start_path = isa_swap_pkg::PATH_HH;
          end else begin
            start_path = req.read ? isa_swap_pkg::PATH_L2H : isa_swap_pkg::PATH_H2L;
          end
        end
        2'b00: begin
          start_path = xcs16 ? isa_swap_pkg::PATH_WORD : isa_swap_pkg::PATH_LL;
          start_16   = xcs16;
        end
        2'b11: start_path = isa_swap_pkg::PATH_NONE;
      endcase
    end
  end

  always_comb begin
    next_state       = state;
    next_path        = path;
    next_cycle_16    = cycle_16;
    next_dma_illegal = dma_illegal;
    unique case (state)
      isa_swap_pkg::ST_IDLE: begin
        if (req.active) begin
          next_state       = isa_swap_pkg::ST_ACTIVE;
          next_path        = start_path;
          next_cycle_16    = start_16;
          next_dma_illegal = start_illegal;
        end
      end
      isa_swap_pkg::ST_ACTIVE: begin
        if (!req.active) begin
          next_state       = isa_swap_pkg::ST_IDLE;
          next_path        = isa_swap_pkg::PATH_NONE;
          next_cycle_16    = 1'b0;
          next_dma_illegal = 1'b0;
        end
      end
      default: begin
        next_state = isa_swap_pkg::ST_IDLE;
        next_path  = isa_swap_pkg::PATH_NONE;
      end
    endcase
  end

  // Only the cross-lane drivers belong to the swapper; straight lanes need no drive
  always_comb begin
    next_data_out = '0;
    next_lo_oe    = 1'b0;
    next_hi_oe    = 1'b0;
    if (req.active && next_state == isa_swap_pkg::ST_ACTIVE) begin
      if (next_path == isa_swap_pkg::PATH_H2L) begin
        next_data_out.lo = data_in.hi;
        next_lo_oe       = 1'b1;
      end else if (next_path == isa_swap_pkg::PATH_L2H) begin
        next_data_out.hi = data_in.lo;
        next_hi_oe       = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state       <= isa_swap_pkg::ST_IDLE;
      path        <= isa_swap_pkg::PATH_NONE;
      cycle_16    <= 1'b0;
      dma_illegal <= 1'b0;
      data_out    <= '0;
      lo_oe       <= 1'b0;
      hi_oe       <= 1'b0;
    end else begin
      state       <= next_state;
      path        <= next_path;
      cycle_16    <= next_cycle_16;
      dma_illegal <= next_dma_illegal;
      data_out    <= next_data_out;
      lo_oe       <= next_lo_oe;
      hi_oe       <= next_hi_oe;
    end
  end

  // Address decode and refresh timer
  logic [11:0] refresh_cnt;
  logic [11:0] next_refresh_cnt;
  logic        next_refresh_req;
  logic        next_mcs16_plat_oe;
  logic        next_io_plat_sel;
  logic        next_io_bus_sel;
  logic [15:0] irq_prev;
  logic [15:0] next_irq_event;

  always_comb begin
    // LA alone sizes memory, so every 128KB block has one width
    next_mcs16_plat_oe = !req.io && !req.refresh &&
                         ((la < isa_swap_pkg::DRAM_TOP_BLOCK) ||
                          (la >= isa_swap_pkg::ROM_BLOCK_LOW && la <= isa_swap_pkg::ROM_BLOCK_HIGH));
    next_io_plat_sel   = req.active && req.io && !req.dma &&
                         (io_addr[isa_swap_pkg::IO_PLAT_MSB:isa_swap_pkg::IO_PLAT_LSB] == 8'h00);
    next_io_bus_sel    = req.active && req.io && !req.dma &&
                         (io_addr[isa_swap_pkg::IO_PLAT_MSB:isa_swap_pkg::IO_PLAT_LSB] != 8'h00);
    next_refresh_req   = 1'b0;
    next_refresh_cnt   = refresh_cnt + 12'h001;
    if (refresh_cnt == 12'(isa_swap_pkg::REFRESH_CYCLES - 1)) begin
      next_refresh_cnt = '0;
      next_refresh_req = 1'b1;
    end
    next_irq_event = irq_line & ~irq_prev;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mcs16_plat_oe <= 1'b0;
      io_plat_sel   <= 1'b0;
      io_bus_sel    <= 1'b0;
      refresh_cnt   <= '0;
      refresh_req   <= 1'b0;
      irq_prev      <= 16'hffff;
      irq_event     <= '0;
    end else begin
      mcs16_plat_oe <= next_mcs16_plat_oe;
      io_plat_sel   <= next_io_plat_sel;
      io_bus_sel    <= next_io_bus_sel;
      refresh_cnt   <= next_refresh_cnt;
      refresh_req   <= next_refresh_req;
      irq_prev      <= irq_line;
      irq_event     <= next_irq_event;
    end
  end

  // Checks
  logic [12:0] since_refresh;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_refresh <= '0;
    end else begin
      since_refresh <= refresh_req ? 13'h0000 : since_refresh + 13'h0001;
    end
  end

  chk_refresh_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    since_refresh < 13'(isa_swap_pkg::REFRESH_CYCLES + 1)) else $error("refresh period exceeded");

  chk_refresh_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    refresh_req |=> !refresh_req) else $error("refresh request longer than one cycle");

  chk_irq_rising: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_event != 16'h0000 |-> (irq_event & ~($past(irq_line) & ~$past(irq_line, 2))) == 16'h0000)
    else $error("irq event without rising edge");

  chk_io_platform: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.active && req.io && !req.dma && io_addr[15:8] == 8'h00) |=> io_plat_sel && !io_bus_sel)
    else $error("low io address not sent to platform");

  chk_odd_swap_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == isa_swap_pkg::ST_IDLE && req.active && !req.dma && !req.refresh && !req.sbhe_n && req.a0
     && req.read && !req.io && req.mcs16_n) |=> (path == isa_swap_pkg::PATH_L2H) && hi_oe && !lo_oe)
    else $error("odd byte read to 8-bit resource not swapped");

  chk_odd_no_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == isa_swap_pkg::ST_IDLE && req.active && !req.dma && !req.refresh && !req.sbhe_n && req.a0
     && !req.io && !req.mcs16_n) |=> (path == isa_swap_pkg::PATH_HH) && !hi_oe && !lo_oe)
    else $error("odd byte to 16-bit resource swapped");

  chk_size_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == isa_swap_pkg::ST_ACTIVE && req.active) |=> $stable(cycle_16) && $stable(path))
    else $error("cycle size changed mid cycle");

  chk_dma_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == isa_swap_pkg::ST_IDLE && req.active && req.dma && !req.refresh && req.a0 && !req.mcs16_n
     && req.read) |=> lo_oe && (data_out.lo == $past(data_in.hi))) else $error("dma odd read not swapped");

  chk_dma_illegal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dma_illegal |-> !lo_oe && !hi_oe && !cycle_16) else $error("illegal dma transfer performed");

  chk_oe_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !req.active |=> !lo_oe && !hi_oe) else $error("cross driver on outside command");

  chk_oe_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(lo_oe && hi_oe)) else $error("both cross drivers on");

  cov_word_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
    path == isa_swap_pkg::PATH_WORD && cycle_16);
  cov_write_swap: cover property (@(posedge clk_sys) disable iff (!rst_n)
    path == isa_swap_pkg::PATH_H2L && lo_oe);
  cov_dma_bad: cover property (@(posedge clk_sys) disable iff (!rst_n) dma_illegal);
  cov_irq_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_event != 16'h0000);

endmodule

`default_nettype wire

// ===== sim/isa_card_model.sv
`timescale 1ns/1ns
`default_nettype none
module isa_card_model #(
  parameter logic [6:0]  MEM16_BLOCK = 7'h05,
  parameter logic [15:0] IO16_BASE   = 16'h0300,
  parameter int          IRQ_SEL     = 5
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [6:0]  la,
  input  wire logic [15:0] io_addr,
  input  wire logic        act,
  input  wire logic        io,
  input  wire logic        raise,
  output logic             mcs16_n,
  output logic             iocs16_n,
  output logic [15:0]      irq_line
);
  logic pend;
  // Width comes from the block number alone, so a whole 128KB block shares it
  assign mcs16_n  = ~(la == MEM16_BLOCK);
  // Ten-line decode; the base keeps clear of the first 256 bytes of each 1KB block
  assign iocs16_n = ~(io_addr[9:0] == IO16_BASE[9:0]);
  assign irq_line = pend ? (16'h0001 << IRQ_SEL) : 16'h0000;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (raise) begin
      pend <= 1'b1;
    end else if (act && io && io_addr[9:0] == IO16_BASE[9:0]) begin
      pend <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/isa_byte_swap_and_sizing_test.sv
`timescale 1ns/1ns
`default_nettype none
module isa_byte_swap_and_sizing_test;
  logic                   clk_sys = 1'b0;
  logic                   rst_n   = 1'b0;
  logic                   act, rd, io, dma, rf, sbhe_n, a0, raise;
  logic [6:0]             la;
  logic [15:0]            io_addr;
  logic [15:0]            irq_line;
  logic [15:0]            irq_event;
  logic                   card_mcs16_n, iocs16_n, plat_oe, plat_sel, bus_sel, refresh_req;
  logic                   cycle_16, dma_illegal, lo_oe, hi_oe;
  isa_swap_pkg::cyc_req_s req;
  isa_swap_pkg::path_e    path;
  isa_swap_pkg::data_s    data_out;
  isa_swap_pkg::data_s    data_in = '{lo: 8'h5a, hi: 8'hc3};
  int                     fail_count = 0;
  int                     tests_run  = 0;
  int                     ev_cnt = 0, ref_gap = 0, ref_last = 0, cyc = 0;

  always #2 clk_sys = ~clk_sys;
  // Open-drain select: the platform pulls it low for its own 16-bit blocks
  assign req = '{act, rd, io, dma, rf, sbhe_n, a0, card_mcs16_n & ~plat_oe, iocs16_n};

  isa_byte_swap_and_sizing dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .data_in(data_in), .la(la), .io_addr(io_addr),
    .irq_line(irq_line), .mcs16_plat_oe(plat_oe), .io_plat_sel(plat_sel), .io_bus_sel(bus_sel),
    .refresh_req(refresh_req), .irq_event(irq_event), .cycle_16(cycle_16), .dma_illegal(dma_illegal),
    .path(path), .data_out(data_out), .lo_oe(lo_oe), .hi_oe(hi_oe));

  isa_card_model card_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .la(la), .io_addr(io_addr), .act(act), .io(io), .raise(raise),
    .mcs16_n(card_mcs16_n), .iocs16_n(iocs16_n), .irq_line(irq_line));

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ev_cnt <= ev_cnt + $countones(irq_event);
    if (refresh_req === 1'b1) begin
      ref_gap <= cyc - ref_last;
      ref_last <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // f = {dma, io, refresh, read, sbhe_n, a0}; e = {cycle_16, dma_illegal}
  task automatic cyc_run(input logic [5:0] f, input logic [6:0] l, input logic [15:0] ad,
                         input logic [5:0] ep, input logic [1:0] e);
    @(posedge clk_sys);
    {dma, io, rf, rd, sbhe_n, a0} <= f;
    la <= l;
    io_addr <= ad;
    @(posedge clk_sys);
    act <= 1'b1;
    @(posedge clk_sys);
    #1;
    if (!e[0]) chk(16'(path), 16'(ep));
    chk(16'({cycle_16, dma_illegal}), 16'(e));
    chk(16'({lo_oe, hi_oe}), 16'({ep == isa_swap_pkg::PATH_H2L, ep == isa_swap_pkg::PATH_L2H}));
    chk(16'({plat_sel, bus_sel}), 16'({f[4] && !f[5] && ad < 16'h0100, f[4] && !f[5] && ad >= 16'h0100}));
    if (ep == isa_swap_pkg::PATH_L2H) chk(16'(data_out.hi), 16'(data_in.lo));
    if (ep == isa_swap_pkg::PATH_H2L) chk(16'(data_out.lo), 16'(data_in.hi));
    // Selects and lane flags move mid-cycle; the sizing taken at the start must hold
    // LA wanders on CPU memory and refresh cycles: DMA holds it, I/O keeps it at zero
    @(posedge clk_sys);
    {sbhe_n, a0, la} <= {~f[1], ~f[0], (f[5] || f[4]) ? l : l ^ 7'h01};
    repeat (2) @(posedge clk_sys);
    #1;
    if (!e[0]) chk(16'(path), 16'(ep));
    @(posedge clk_sys);
    act <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(16'({path, lo_oe, hi_oe}), 16'({isa_swap_pkg::PATH_NONE, 2'b00}));
  endtask

  task automatic plat_test();
    for (int k = 0; k < 9; k++) begin
      @(posedge clk_sys);
      // Leftover refresh or I/O flags would mask the platform select
      {dma, io, rf, la} <= {3'b000, (k == 8) ? 7'h7f : 7'(k)};
      repeat (2) @(posedge clk_sys);
      #1;
      chk(16'(plat_oe), 16'(la < isa_swap_pkg::DRAM_TOP_BLOCK || la >= isa_swap_pkg::ROM_BLOCK_LOW));
    end
    $display("platform sizing test done");
  endtask

  task automatic irq_test();
    int c0;
    c0 = ev_cnt;
    @(posedge clk_sys);
    raise <= 1'b1;
    @(posedge clk_sys);
    raise <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(16'(ev_cnt - c0), 16'h0001);
    // An access to the card drops its line; the falling edge must give no event
    cyc_run(6'b010100, 7'h00, 16'h0300, 6'h08, 2'b10);
    repeat (6) @(posedge clk_sys);
    chk(16'(ev_cnt - c0), 16'h0001);
    $display("interrupt edge test done");
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {act, rd, io, dma, rf, sbhe_n, a0, raise} = 8'h04;
    la = 7'h06;
    io_addr = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc_run(6'b000110, 7'h06, 16'h0000, 6'h02, 2'b00);
    cyc_run(6'b000010, 7'h05, 16'h0000, 6'h02, 2'b00);
    cyc_run(6'b000101, 7'h06, 16'h0000, 6'h20, 2'b00);
    cyc_run(6'b000001, 7'h06, 16'h0000, 6'h10, 2'b00);
    cyc_run(6'b000101, 7'h05, 16'h0000, 6'h04, 2'b00);
    cyc_run(6'b000100, 7'h06, 16'h0000, 6'h02, 2'b00);
    cyc_run(6'b000000, 7'h05, 16'h0000, 6'h08, 2'b10);
    cyc_run(6'b010001, 7'h00, 16'h00ff, 6'h10, 2'b00);
    cyc_run(6'b010100, 7'h00, 16'h0100, 6'h02, 2'b00);
    cyc_run(6'b100110, 7'h05, 16'h0000, 6'h02, 2'b00);
    cyc_run(6'b100111, 7'h06, 16'h0000, 6'h02, 2'b00);
    cyc_run(6'b100111, 7'h05, 16'h0000, 6'h10, 2'b00);
    cyc_run(6'b100011, 7'h05, 16'h0000, 6'h20, 2'b00);
    cyc_run(6'b100100, 7'h05, 16'h0000, 6'h08, 2'b10);
    cyc_run(6'b100000, 7'h06, 16'h0300, 6'h01, 2'b01);
    cyc_run(6'b001100, 7'h05, 16'h0030, 6'h01, 2'b00);
    $display("swap and sizing tests done");
    plat_test();
    irq_test();
    repeat (2 * isa_swap_pkg::REFRESH_CYCLES + 10) @(posedge clk_sys);
    chk(16'(ref_gap), 16'(isa_swap_pkg::REFRESH_CYCLES));
    $display("refresh period test done");
    wrap_up();
  end
endmodule
`default_nettype wire
